// ---- hw/mode_desc_pkg.sv ----
// shared constants and types for the mode-bit descriptor link and its two ends
package mode_desc_pkg;

  // descriptor word field positions
  localparam int BIT_AVAIL = 31;
  localparam int BIT_POL = 30;
  localparam int BIT_OTP = 29;
  localparam int BIT_ADDR_MODE = 28;
  localparam int BIT_BYTE1 = 27;
  localparam int POS_LSB = 24;
  localparam int FLD_LSB = 16;
  localparam int RD_OP_LSB = 8;
  localparam int WR_OP_LSB = 0;
  localparam logic [7:0] OPCODE_NONE = 8'h00;

  // link framing: 8 command bits then 32 data bits, msb first
  localparam logic [5:0] LINK_CMD_BITS = 6'h08;
  localparam logic [5:0] LINK_FRAME_BITS = 6'h28;
  localparam int LINK_HALF_CYCLES = 8;
  localparam logic [7:0] LINK_CMD_READ = 8'hB0;

  // controller register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WORD = 8'h08;
  localparam logic [7:0] REG_DECODE = 8'h0C;
  localparam logic [7:0] REG_PLACED = 8'h10;
  localparam logic [7:0] REG_RMW = 8'h14;

  // control register bits
  localparam int CTRL_START = 0;
  localparam int CTRL_INDEX = 1;
  localparam int CTRL_ADDR8 = 2;
  localparam int CTRL_SINGLE = 3;
  localparam int CTRL_WANT = 4;

  // control register reset values
  localparam logic CTRL_INDEX_RST = 1'b0;
  localparam logic CTRL_ADDR8_RST = 1'b0;
  localparam logic CTRL_SINGLE_RST = 1'b0;
  localparam logic CTRL_WANT_RST = 1'b0;

  typedef struct packed {
    logic avail;
    logic pol;
    logic otp;
    logic addr_mode;
    logic byte1;
    logic [2:0] pos;
    logic [7:0] loc_addr;
    logic [3:0] modes;
    logic [3:0] dummy;
    logic [7:0] rd_op;
    logic [7:0] wr_op;
  } desc_cfg_s;

  localparam desc_cfg_s OCT_CFG_DEFAULT = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h3, 8'h02, 4'h0, 4'h0, 8'h11, 8'h22};
  localparam desc_cfg_s RATE_CFG_DEFAULT = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h5, 8'h00, 4'hA, 4'h8, 8'h33, 8'h44};

endpackage : mode_desc_pkg

// ---- hw/desc_link_if.sv ----
// serial link joining the descriptor memory end and the controller end
`timescale 1ns/1ps
interface desc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport mem_end(input sclk, input cs_n, input mosi, output miso);
  modport ctl_end(output sclk, output cs_n, output mosi, input miso);
endinterface : desc_link_if

// ---- hw/desc_mem_end.sv ----
// memory end: serves the two read-only mode-bit descriptor words over the link
`timescale 1ns/1ps
module desc_mem_end
  import mode_desc_pkg::*;
#(
  parameter desc_cfg_s OCT_CFG = OCT_CFG_DEFAULT,
  parameter desc_cfg_s RATE_CFG = RATE_CFG_DEFAULT
) (
  input wire logic mclk_in, // system clock
  input wire logic reset_in, // synchronous reset, active high
  desc_link_if.mem_end link, // serial link toward the controller
  output logic link_active_out, // frame in progress
  output logic last_index_out, // index of the last word served
  output logic bad_cmd_out // last command byte was not a read
);

  ////////////////////////////////////////////////////////////////////////////
  // descriptor word assembly

  function automatic logic [31:0] build_word(input desc_cfg_s c, input logic is_rate);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[BIT_AVAIL] = c.avail;
    w[BIT_POL] = c.pol;
    w[BIT_OTP] = is_rate ? 1'b0 : c.otp;
    w[BIT_ADDR_MODE] = c.addr_mode;
    w[BIT_BYTE1] = c.byte1;
    w[POS_LSB +: 3] = c.pos;
    if (c.addr_mode) begin
      w[FLD_LSB +: 8] = c.loc_addr;
    end else begin
      // mode flags 23..20 then the one shared dummy count
      w[FLD_LSB +: 8] = {c.modes, c.dummy};
    end
    w[RD_OP_LSB +: 8] = c.rd_op;
    w[WR_OP_LSB +: 8] = c.wr_op;
    return w;
  endfunction : build_word

  localparam logic [31:0] OCT_WORD = build_word(OCT_CFG, 1'b0);
  localparam logic [31:0] RATE_WORD = build_word(RATE_CFG, 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0] sclk_sy;
    logic [1:0] cs_sy;
    logic [1:0] mosi_sy;
    logic sclk_prev;
    logic [5:0] cnt;
    logic [7:0] cmd;
    logic [31:0] shift;
    logic miso;
    logic active;
    logic last_idx;
    logic bad_cmd;
  } mem_state_s;

  mem_state_s s_ff;
  mem_state_s nxt_s;

  always_comb begin
    logic rise;
    logic fall;
    logic [7:0] cmd_now;
    rise = 1'b0;
    fall = 1'b0;
    cmd_now = 8'h00;
    nxt_s = s_ff;
    // pins pass two flops; only index 1 is read by logic
    nxt_s.sclk_sy = {s_ff.sclk_sy[0], link.sclk};
    nxt_s.cs_sy = {s_ff.cs_sy[0], link.cs_n};
    nxt_s.mosi_sy = {s_ff.mosi_sy[0], link.mosi};
    nxt_s.sclk_prev = s_ff.sclk_sy[1];
    rise = s_ff.sclk_sy[1] & ~s_ff.sclk_prev;
    fall = ~s_ff.sclk_sy[1] & s_ff.sclk_prev;
    if (s_ff.cs_sy[1]) begin
      nxt_s.cnt = 6'h00;
      nxt_s.miso = 1'b0;
      nxt_s.active = 1'b0;
    end else begin
      nxt_s.active = 1'b1;
      if (rise) begin
        if (s_ff.cnt < LINK_CMD_BITS) begin
          cmd_now = {s_ff.cmd[6:0], s_ff.mosi_sy[1]};
          nxt_s.cmd = cmd_now;
          if (s_ff.cnt == LINK_CMD_BITS - 6'h01) begin
            if (cmd_now[7:1] == LINK_CMD_READ[7:1]) begin
              nxt_s.shift = cmd_now[0] ? RATE_WORD : OCT_WORD;
              nxt_s.last_idx = cmd_now[0];
              nxt_s.bad_cmd = 1'b0;
            end else begin
              // unknown command answers with all zeros
              nxt_s.shift = 32'h0000_0000;
              nxt_s.bad_cmd = 1'b1;
            end
          end
        end
        if (s_ff.cnt < LINK_FRAME_BITS) begin
          nxt_s.cnt = s_ff.cnt + 6'h01;
        end
      end
      // data changes on the falling edge so it is stable at the next rising one
      if (fall && s_ff.cnt >= LINK_CMD_BITS && s_ff.cnt < LINK_FRAME_BITS) begin
        nxt_s.miso = s_ff.shift[31];
        nxt_s.shift = {s_ff.shift[30:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s_ff <= '{sclk_sy: 2'h0, cs_sy: 2'h3, mosi_sy: 2'h0, sclk_prev: 1'b0, cnt: 6'h00, cmd: 8'h00,
                shift: 32'h0000_0000, miso: 1'b0, active: 1'b0, last_idx: 1'b0, bad_cmd: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.miso = s_ff.miso;
  assign link_active_out = s_ff.active;
  assign last_index_out = s_ff.last_idx;
  assign bad_cmd_out = s_ff.bad_cmd;

endmodule : desc_mem_end

// ---- hw/desc_ctl_end.sv ----
// controller end: fetches a descriptor word over the link and decodes it for software
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module desc_ctl_end
  import mode_desc_pkg::*;
#(
  parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
  input wire logic mclk_in, // system clock
  input wire logic reset_in, // synchronous reset, active high
  input wire logic wb_cyc_in, // wishbone cycle
  input wire logic wb_stb_in, // wishbone strobe
  input wire logic wb_we_in, // wishbone write enable
  input wire logic [7:0] wb_adr_in, // wishbone byte address
  input wire logic [3:0] wb_sel_in, // wishbone byte selects
  input wire logic [31:0] wb_dat_in, // wishbone write data
  output logic [31:0] wb_dat_out, // wishbone read data
  output logic wb_ack_out, // wishbone acknowledge
  desc_link_if.ctl_end link, // serial link toward the memory
  output logic busy_out, // fetch in progress
  output logic access_ok_out, // fetched bit is reachable
  output logic [3:0] dummy_out // dummy cycles to use for the direct command
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic idx;
    logic addr8;
    logic single;
    logic want;
    logic [7:0] rmw_in;
    logic busy;
    logic done;
    logic [31:0] word;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic [5:0] cnt;
    logic [7:0] cmd;
    logic [31:0] rx;
    logic [1:0] miso_sy;
    logic access_ok;
    logic [3:0] dummy;
  } ctl_state_s;

  ctl_state_s s_ff;
  ctl_state_s nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  // decode of a fetched word

  logic [31:0] w;
  logic am;
  logic place_bad;
  logic rd_ok;
  logic wr_ok;
  logic acc_ok;
  logic [3:0] eff_dummy;
  logic [31:0] placed;
  logic [7:0] rmw_out;
  logic [31:0] decode;

  always_comb begin
    w = s_ff.word;
    am = w[BIT_ADDR_MODE];
    place_bad = am & w[BIT_BYTE1] & s_ff.addr8;
    rd_ok = w[RD_OP_LSB +: 8] != OPCODE_NONE;
    wr_ok = w[WR_OP_LSB +: 8] != OPCODE_NONE;
    acc_ok = w[BIT_AVAIL] & rd_ok & wr_ok & ~place_bad;
    // single-lane use ignores the encoded count; flags only advise
    eff_dummy = (s_ff.single || am) ? 4'h0 : w[FLD_LSB +: 4];
    placed = 32'h0000_0000;
    if (am) begin
      placed = w[BIT_BYTE1] ? {16'h0000, w[FLD_LSB +: 8], 8'h00} : {24'h00_0000, w[FLD_LSB +: 8]};
    end
    rmw_out = s_ff.rmw_in;
    if (acc_ok) begin
      rmw_out[w[POS_LSB +: 3]] = s_ff.want ^ w[BIT_POL];
    end
    decode = {4'h0, place_bad, acc_ok, wr_ok, rd_ok, eff_dummy, w[23:20], w[FLD_LSB +: 8],
              w[POS_LSB +: 3], w[BIT_BYTE1], am, w[BIT_OTP], w[BIT_POL], w[BIT_AVAIL]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave and link sequencer

  always_comb begin
    logic req;
    logic wr_now;
    logic [7:0] cmd0;
    req = wb_cyc_in & wb_stb_in & ~s_ff.ack;
    wr_now = wb_cyc_in & wb_stb_in & wb_we_in & s_ff.ack & wb_sel_in[0];
    cmd0 = 8'h00;
    nxt_s = s_ff;
    nxt_s.miso_sy = {s_ff.miso_sy[0], link.miso};
    nxt_s.ack = req;
    if (req && !wb_we_in) begin
      unique case (wb_adr_in)
        REG_CTRL: nxt_s.rdata = {27'h0, s_ff.want, s_ff.single, s_ff.addr8, s_ff.idx, 1'b0};
        REG_STATUS: nxt_s.rdata = {30'h0, s_ff.done, s_ff.busy};
        REG_WORD: nxt_s.rdata = s_ff.word;
        REG_DECODE: nxt_s.rdata = decode;
        REG_PLACED: nxt_s.rdata = placed;
        REG_RMW: nxt_s.rdata = {24'h00_0000, rmw_out};
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end
    // a write lands on the edge where the master sees ack
    if (wr_now && wb_adr_in == REG_RMW) begin
      nxt_s.rmw_in = wb_dat_in[7:0];
    end
    if (wr_now && wb_adr_in == REG_CTRL) begin
      nxt_s.idx = wb_dat_in[CTRL_INDEX];
      nxt_s.addr8 = wb_dat_in[CTRL_ADDR8];
      nxt_s.single = wb_dat_in[CTRL_SINGLE];
      nxt_s.want = wb_dat_in[CTRL_WANT];
      // start while busy is ignored
      if (wb_dat_in[CTRL_START] && !s_ff.busy) begin
        cmd0 = {LINK_CMD_READ[7:1], wb_dat_in[CTRL_INDEX]};
        nxt_s.cmd = cmd0;
        nxt_s.mosi = cmd0[7];
        nxt_s.busy = 1'b1;
        nxt_s.done = 1'b0;
        nxt_s.cs_n = 1'b0;
        nxt_s.sclk = 1'b0;
        nxt_s.cnt = 6'h00;
        nxt_s.div = 8'h00;
      end
    end
    if (s_ff.busy) begin
      nxt_s.div = s_ff.div + 8'h01;
      if (s_ff.div == 8'(HALF_CYCLES - 1)) begin
        nxt_s.div = 8'h00;
        nxt_s.sclk = ~s_ff.sclk;
        if (!s_ff.sclk) begin
          if (s_ff.cnt >= LINK_CMD_BITS) begin
            nxt_s.rx = {s_ff.rx[30:0], s_ff.miso_sy[1]};
          end
          nxt_s.cnt = s_ff.cnt + 6'h01;
        end else if (s_ff.cnt == LINK_FRAME_BITS) begin
          nxt_s.cs_n = 1'b1;
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.mosi = 1'b0;
          nxt_s.word = s_ff.rx;
          nxt_s.access_ok = s_ff.rx[BIT_AVAIL] && s_ff.rx[RD_OP_LSB +: 8] != OPCODE_NONE
                            && s_ff.rx[WR_OP_LSB +: 8] != OPCODE_NONE
                            && !(s_ff.rx[BIT_ADDR_MODE] && s_ff.rx[BIT_BYTE1] && s_ff.addr8);
          nxt_s.dummy = (s_ff.single || s_ff.rx[BIT_ADDR_MODE]) ? 4'h0 : s_ff.rx[FLD_LSB +: 4];
        end else begin
          nxt_s.cmd = {s_ff.cmd[6:0], 1'b0};
          nxt_s.mosi = (s_ff.cnt < LINK_CMD_BITS) ? s_ff.cmd[6] : 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s_ff <= '{ack: 1'b0, rdata: 32'h0000_0000, idx: CTRL_INDEX_RST, addr8: CTRL_ADDR8_RST,
                single: CTRL_SINGLE_RST, want: CTRL_WANT_RST, rmw_in: 8'h00, busy: 1'b0, done: 1'b0,
                word: 32'h0000_0000, div: 8'h00, sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0, cnt: 6'h00,
                cmd: 8'h00, rx: 32'h0000_0000, miso_sy: 2'h0, access_ok: 1'b0, dummy: 4'h0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_dat_out = s_ff.rdata;
  assign wb_ack_out = s_ff.ack;
  assign link.sclk = s_ff.sclk;
  assign link.cs_n = s_ff.cs_n;
  assign link.mosi = s_ff.mosi;
  assign busy_out = s_ff.busy;
  assign access_ok_out = s_ff.access_ok;
  assign dummy_out = s_ff.dummy;

endmodule : desc_ctl_end

// ---- sim/mode_bit_descriptor_decode_properties.sv ----
// concurrent checks on the descriptor words carried over the serial link
`timescale 1ns/1ps
module mode_bit_descriptor_decode_properties
  import mode_desc_pkg::*;
#(
  parameter desc_cfg_s OCT_CFG = OCT_CFG_DEFAULT,
  parameter desc_cfg_s RATE_CFG = RATE_CFG_DEFAULT
) (
  input wire logic mclk_in, // system clock
  input wire logic reset_in, // synchronous reset, active high
  input wire logic sclk, // link clock
  input wire logic cs_n, // frame select, active low
  input wire logic mosi, // controller to memory data
  input wire logic miso // memory to controller data
);
  ////////////////////////////////////////////////////////////////////////
  logic sclk_q;
  logic cs_q;
  logic [39:0] cmd_sh;
  logic [31:0] dat_sh;
  logic [5:0] bits;
  logic fin;
  logic idx;
  desc_cfg_s cfg;

  // both lines are taken on sclk rises, where the controller samples too
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      cmd_sh <= 40'h0;
      dat_sh <= 32'h0;
      bits <= 6'h0;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      if (cs_n) begin
        bits <= 6'h0;
      end else if (sclk && !sclk_q) begin
        cmd_sh <= {cmd_sh[38:0], mosi};
        dat_sh <= {dat_sh[30:0], miso};
        bits <= bits + 6'h01;
      end
    end
  end

  // a frame counts only when whole and carrying the read command
  assign fin = cs_n && !cs_q && (bits == LINK_FRAME_BITS) && (cmd_sh[39:33] == LINK_CMD_READ[7:1]);
  assign idx = cmd_sh[32];
  assign cfg = idx ? RATE_CFG : OCT_CFG;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  a_oct_avail_pol: assert property (fin && !idx |-> dat_sh[31:30] == {OCT_CFG.avail, OCT_CFG.pol})
    else $error("octal word availability or polarity wrong");
  a_oct_otp_flag: assert property (fin && !idx |-> dat_sh[29] == OCT_CFG.otp)
    else $error("octal word one-time flag wrong");
  a_oct_bit_pos: assert property (fin && !idx |-> dat_sh[26:24] == OCT_CFG.pos)
    else $error("octal word bit position wrong");
  a_reg_address: assert property (fin && dat_sh[28] |-> dat_sh[23:16] == cfg.loc_addr)
    else $error("register address field wrong");
  a_mode_flags: assert property (fin && !dat_sh[28] |-> dat_sh[23:20] == cfg.modes)
    else $error("direct mode flags wrong");
  a_dummy_count: assert property (fin && !dat_sh[28] |-> dat_sh[19:16] == cfg.dummy)
    else $error("dummy count field wrong");
  a_opcode_fields: assert property (fin |-> dat_sh[15:0] == {cfg.rd_op, cfg.wr_op})
    else $error("read or write opcode field wrong");
  a_rate_avail_pol: assert property (fin && idx |-> dat_sh[31:30] == {RATE_CFG.avail, RATE_CFG.pol})
    else $error("rate word availability or polarity wrong");
  a_rate_reserved: assert property (fin && idx |-> !dat_sh[29])
    else $error("rate word reserved bit set");
  a_access_style: assert property (fin |-> dat_sh[28:27] == {cfg.addr_mode, cfg.byte1})
    else $error("access style or placement flag wrong");
  a_rate_bit_pos: assert property (fin && idx |-> dat_sh[26:24] == RATE_CFG.pos)
    else $error("rate word bit position wrong");

  c_oct_frame: cover property (fin && !idx);
  c_rate_frame: cover property (fin && idx);
  c_direct_word: cover property (fin && !dat_sh[28]);
  c_byte1_word: cover property (fin && dat_sh[28] && dat_sh[27]);
endmodule : mode_bit_descriptor_decode_properties

// ---- sim/mode_bit_descriptor_decode_tb.sv ----
// self-checking bench: controller end fetches and decodes words from the memory end
`timescale 1ns/1ps
module mode_bit_descriptor_decode_tb;
  import mode_desc_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_dat_out;
  logic wb_ack_out;
  logic busy_out;
  logic access_ok_out;
  logic [3:0] dummy_out;
  logic last_index_out;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  logic [7:0] lfsr = 8'h60;
  logic link_active_out;
  logic bad_cmd_out;
  // octal word set to addressed, byte-one placement and one-time flag so those decode paths get exercised
  localparam desc_cfg_s OCT_TB = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 3'h6, 8'h5A, 4'h0, 4'h0, 8'h11, 8'h22};
  desc_link_if link();

  desc_mem_end #(.OCT_CFG(OCT_TB)) desc_mem_end_i (.mclk_in(mclk_in), .reset_in(reset_in), .link(link),
    .link_active_out(link_active_out), .last_index_out(last_index_out), .bad_cmd_out(bad_cmd_out));
  desc_ctl_end desc_ctl_end_i (.mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
    .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .link(link), .busy_out(busy_out), .access_ok_out(access_ok_out), .dummy_out(dummy_out));
  mode_bit_descriptor_decode_properties #(.OCT_CFG(OCT_TB)) mode_bit_descriptor_decode_properties_i (
    .mclk_in(mclk_in), .reset_in(reset_in), .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso(link.miso));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 mclk_in = ~mclk_in;
  end

  // a hang anywhere ends the run as a failure
  always @(posedge mclk_in) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      n_mismatch++;
      close_out();
    end
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] l);
    return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
  endfunction : lfsr_next

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // classic single cycle; holds everything until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_in);
    // ack stands one cycle only, so it must be low again before the next request
    chk("ack idle", 32'h0, {31'h0, wb_ack_out});
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= d;
    // no cycle count assumed: only the bench watchdog ends a wait
    do begin
      @(posedge mclk_in);
    end while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_cycle

  ////////////////////////////////////////////////////////////////////////
  logic [4:0] plan [5] = '{5'h11, 5'h03, 5'h1B, 5'h05, 5'h17};

  initial begin
    logic [31:0] q;
    logic [31:0] w;
    logic [31:0] dec;
    logic [31:0] plc;
    logic [7:0] e;
    logic [3:0] dum;
    logic idx;
    logic a8;
    logic sgl;
    logic want;
    logic pbad;
    logic ok;
    int n;
    desc_cfg_s c;
    repeat (8) @(posedge mclk_in);
    reset_in <= 1'b0;
    wb_cycle(1'b0, 8'h20, 32'h0, q);
    chk("unmapped", 32'h0, q);
    foreach (plan[k]) begin
      {want, sgl, a8, idx} = plan[k][4:1];
      c = idx ? RATE_CFG_DEFAULT : OCT_TB;
      // word model: field layout with the rate word reserved bit held at zero
      w = {c.avail, c.pol, idx ? 1'b0 : c.otp, c.addr_mode, c.byte1, c.pos,
           c.addr_mode ? c.loc_addr : {c.modes, c.dummy}, c.rd_op, c.wr_op};
      // byte-one placement only matters for addressed access
      pbad = w[28] & w[27] & a8;
      ok = w[31] & (|w[15:8]) & (|w[7:0]) & !pbad;
      dum = (w[28] | sgl) ? 4'h0 : w[19:16];
      dec = {4'h0, pbad, ok, |w[7:0], |w[15:8], dum, w[23:20], w[23:16], w[26:24], w[27], w[28], w[29], w[30], w[31]};
      plc = !w[28] ? 32'h0 : (w[27] ? {16'h0, w[23:16], 8'h00} : {24'h0, w[23:16]});
      wb_cycle(1'b1, REG_CTRL, {27'h0, plan[k]}, q);
      // a frame lasts hundreds of cycles, so the first poll must see busy set and done cleared
      wb_cycle(1'b0, REG_STATUS, 32'h0, q);
      chk("status start", 32'h1, q);
      n = 0;
      do begin
        wb_cycle(1'b0, REG_STATUS, 32'h0, q);
        n++;
      end while (q[1] !== 1'b1 && n < 400);
      chk("status", 32'h2, q);
      wb_cycle(1'b0, REG_WORD, 32'h0, q);
      chk("word", w, q);
      wb_cycle(1'b0, REG_DECODE, 32'h0, q);
      chk("decode", dec, q);
      wb_cycle(1'b0, REG_PLACED, 32'h0, q);
      chk("placed", plc, q);
      chk("dummy", {28'h0, dum}, {28'h0, dummy_out});
      chk("access", {31'h0, ok}, {31'h0, access_ok_out});
      chk("index", {31'h0, idx}, {31'h0, last_index_out});
      chk("busy", 32'h0, {31'h0, busy_out});
      chk("active", 32'h0, {31'h0, link_active_out});
      chk("bad cmd", 32'h0, {31'h0, bad_cmd_out});
      lfsr = lfsr_next(lfsr);
      e = lfsr;
      if (ok) e[w[26:24]] = want ^ w[30];
      wb_cycle(1'b1, REG_RMW, {24'h0, lfsr}, q);
      wb_cycle(1'b0, REG_RMW, 32'h0, q);
      chk("rmw", {24'h0, e}, {24'h0, q[7:0]});
    end
    close_out();
  end
endmodule : mode_bit_descriptor_decode_tb
